// ### serial_cfg_pkg.sv
// Purpose: Shared constants for the serial node switch configuration block
// Assumes: 50 MHz pclk, 32-bit APB data, 12-bit APB address
// Notes:   Offsets are byte addresses of aligned 32-bit words
package serial_cfg_pkg;

	// ************************************************************
	// Clock and bit rates
	// ************************************************************
	localparam int CLK_HZ          = 50_000_000;
	localparam int RATE_9K6_BPS    = 9_600;
	localparam int RATE_38K4_BPS   = 38_400;
	localparam int RATE_115K2_BPS  = 115_200;
	localparam int DIV_W           = 13;
	localparam logic [DIV_W-1:0] DIV_9K6   = DIV_W'(CLK_HZ / RATE_9K6_BPS);
	localparam logic [DIV_W-1:0] DIV_38K4  = DIV_W'(CLK_HZ / RATE_38K4_BPS);
	localparam logic [DIV_W-1:0] DIV_115K2 = DIV_W'(CLK_HZ / RATE_115K2_BPS);

	// ************************************************************
	// Switch fields and codes
	// ************************************************************
	localparam int SW_W       = 8;
	localparam int ADDR_W     = 6;
	localparam int RATE_W     = 2;
	localparam int ADDR_LSB   = 0;
	localparam int RATE_LSB   = 6;
	localparam logic [ADDR_W-1:0] ADDR_USE_NV = 6'h00;
	localparam logic [RATE_W-1:0] RATE_USE_NV = 2'h0;
	localparam logic [RATE_W-1:0] RATE_9K6    = 2'h1;
	localparam logic [RATE_W-1:0] RATE_38K4   = 2'h2;
	localparam logic [RATE_W-1:0] RATE_115K2  = 2'h3;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int PADDR_W = 12;
	localparam logic [PADDR_W-1:0] OFS_NV_CFG  = 12'h000;
	localparam logic [PADDR_W-1:0] OFS_RS232   = 12'h004;
	localparam logic [PADDR_W-1:0] OFS_STATUS  = 12'h008;
	localparam logic [PADDR_W-1:0] OFS_BAUDDIV = 12'h00c;
	localparam int NV_ADDR_LSB   = 0;
	localparam int NV_RATE_LSB   = 8;
	localparam int RS232_W       = 16;
	localparam int ST_SW_LSB     = 0;
	localparam int ST_ADDR_LSB   = 8;
	localparam int ST_RATE_LSB   = 16;
	localparam int ST_ADDR_NV    = 18;
	localparam int ST_RATE_NV    = 19;
	localparam int ST_RS485      = 20;
	localparam logic [ADDR_W-1:0]  NV_ADDR_RST = 6'h00;
	localparam logic [RATE_W-1:0]  NV_RATE_RST = 2'h0;
	localparam logic [RS232_W-1:0] RS232_RST   = 16'h0000;

endpackage

// ### cfg_if.sv
// Purpose: Carries switch and stored values to the decoder and results back
// Assumes: Purely combinational decoder on the far side
// Notes:   Used only between the top module and its decoder
`timescale 1ns/1ps
interface cfg_if;
	import serial_cfg_pkg::*;
	logic [SW_W-1:0]   sw;
	logic [ADDR_W-1:0] nv_addr;
	logic [RATE_W-1:0] nv_rate;
	logic [ADDR_W-1:0] node_addr;
	logic [RATE_W-1:0] rate_code;
	logic [DIV_W-1:0]  baud_div;
	logic              addr_nv;
	logic              rate_nv;
	modport dec (input sw, nv_addr, nv_rate,
		output node_addr, rate_code, baud_div, addr_nv, rate_nv);
	modport user (output sw, nv_addr, nv_rate,
		input node_addr, rate_code, baud_div, addr_nv, rate_nv);
endinterface

// ### switch_decode.sv
// Purpose: Decodes the eight switches into RS-485 address and bit rate
// Assumes: Closed switch reads as one
// Notes:   Zero fields fall back to the stored values
`timescale 1ns/1ps
module switch_decode
	import serial_cfg_pkg::*;
(
	cfg_if.dec c
);

	logic [ADDR_W-1:0] sw_addr;
	logic [RATE_W-1:0] sw_rate;
	logic [RATE_W-1:0] eff_rate;

	always_comb begin
		// R1 address from switches
		sw_addr     = c.sw[ADDR_LSB +: ADDR_W];
		// R2 rate from switches
		sw_rate     = c.sw[RATE_LSB +: RATE_W];
		// R4 stored address fallback
		c.addr_nv   = (sw_addr == ADDR_USE_NV);
		c.node_addr = c.addr_nv ? c.nv_addr : sw_addr;
		// R5 stored rate fallback
		c.rate_nv   = (sw_rate == RATE_USE_NV);
		eff_rate    = c.rate_nv ? c.nv_rate : sw_rate;
		// Empty stored rate defaults to the slowest rate
		c.rate_code = (eff_rate == RATE_USE_NV) ? RATE_9K6 : eff_rate;
		// R6 code to bit rate
		case (c.rate_code)
			RATE_38K4:  c.baud_div = DIV_38K4;
			RATE_115K2: c.baud_div = DIV_115K2;
			default:    c.baud_div = DIV_9K6;
		endcase
	end

endmodule // switch_decode

// ### serial_node_switch_config.sv
// What this block does
// R1 - Switches 1-6 form address, switch1 LSB
// R2 - Switches 7-8 form bit-rate code
// R3 - Switches never alter RS-232 settings
// R4 - Zero address uses stored address
// R5 - Zero rate code uses stored rate
// R6 - Codes 1/2/3 give 9.6/38.4/115.2 kbps
// R7 - Grounded select gives RS-485, else RS-232
//
// Purpose: Switch decode for the serial port, with an APB register file
// Assumes: Inputs synchronous to pclk; switch closed drives one
// Notes:   Outputs settle two pclk edges after a switch change
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module serial_node_switch_config
	import serial_cfg_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [PADDR_W-1:0]   paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [SW_W-1:0]      sw_closed,
	input  wire logic                 select_pin,
	output logic                      rs485_mode,
	output logic      [ADDR_W-1:0]    node_addr,
	output logic      [RATE_W-1:0]    rate_code,
	output logic      [DIV_W-1:0]     baud_div,
	output logic                      addr_from_nv,
	output logic                      rate_from_nv,
	output logic      [RS232_W-1:0]   rs232_cfg
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [SW_W-1:0]    sw_q,          sw_d;
	logic               sel_q,         sel_d;
	logic [ADDR_W-1:0]  nv_addr_q,     nv_addr_d;
	logic [RATE_W-1:0]  nv_rate_q,     nv_rate_d;
	logic [RS232_W-1:0] rs232_cfg_q,   rs232_cfg_d;
	logic               rs485_mode_q,  rs485_mode_d;
	logic [ADDR_W-1:0]  node_addr_q,   node_addr_d;
	logic [RATE_W-1:0]  rate_code_q,   rate_code_d;
	logic [DIV_W-1:0]   baud_div_q,    baud_div_d;
	logic               addr_nv_q,     addr_nv_d;
	logic               rate_nv_q,     rate_nv_d;
	logic [31:0]        prdata_q,      prdata_d;
	logic               pready_q,      pready_d;
	logic               pslverr_q,     pslverr_d;
	logic               setup;
	logic               wr_en;
	logic               mapped;

	cfg_if cfg ();

	// ************************************************************
	// Decoder
	// ************************************************************
	assign cfg.sw      = sw_q;
	assign cfg.nv_addr = nv_addr_q;
	assign cfg.nv_rate = nv_rate_q;

	switch_decode u_dec (
		.c (cfg.dec)
	);

	// ************************************************************
	// APB slave
	// ************************************************************
	// Answer in the cycle after setup, with no wait states
	assign setup  = psel & ~penable;
	assign wr_en  = psel & penable & pready_q & pwrite;
	assign mapped = (paddr == OFS_NV_CFG) || (paddr == OFS_RS232) ||
		(paddr == OFS_STATUS) || (paddr == OFS_BAUDDIV);

	always_comb begin
		pready_d  = setup;
		pslverr_d = setup & ~mapped;
		prdata_d  = prdata_q;
		if (setup) begin
			prdata_d = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					OFS_NV_CFG: begin
						prdata_d[NV_ADDR_LSB +: ADDR_W] = nv_addr_q;
						prdata_d[NV_RATE_LSB +: RATE_W] = nv_rate_q;
					end
					OFS_RS232: begin
						prdata_d[RS232_W-1:0] = rs232_cfg_q;
					end
					OFS_STATUS: begin
						prdata_d[ST_SW_LSB +: SW_W]     = sw_q;
						prdata_d[ST_ADDR_LSB +: ADDR_W] = node_addr_q;
						prdata_d[ST_RATE_LSB +: RATE_W] = rate_code_q;
						prdata_d[ST_ADDR_NV]            = addr_nv_q;
						prdata_d[ST_RATE_NV]            = rate_nv_q;
						prdata_d[ST_RS485]              = rs485_mode_q;
					end
					OFS_BAUDDIV: begin
						prdata_d[DIV_W-1:0] = baud_div_q;
					end
					default: begin
						prdata_d = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ************************************************************
	// Software registers
	// ************************************************************
	always_comb begin
		nv_addr_d   = nv_addr_q;
		nv_rate_d   = nv_rate_q;
		rs232_cfg_d = rs232_cfg_q;
		if (wr_en && paddr == OFS_NV_CFG) begin
			nv_addr_d = pwdata[NV_ADDR_LSB +: ADDR_W];
			nv_rate_d = pwdata[NV_RATE_LSB +: RATE_W];
		end
		// R3 RS-232 software only
		if (wr_en && paddr == OFS_RS232) begin
			rs232_cfg_d = pwdata[RS232_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nv_addr_q   <= NV_ADDR_RST;
			nv_rate_q   <= NV_RATE_RST;
			rs232_cfg_q <= RS232_RST;
		end else begin
			nv_addr_q   <= nv_addr_d;
			nv_rate_q   <= nv_rate_d;
			rs232_cfg_q <= rs232_cfg_d;
		end
	end

	// ************************************************************
	// Switch capture and decoded outputs
	// ************************************************************
	always_comb begin
		// Capture edge, then decode edge: pins to outputs take two
		sw_d         = sw_closed;
		sel_d        = select_pin;
		// R7 grounded select
		rs485_mode_d = ~sel_q;
		node_addr_d  = cfg.node_addr;
		rate_code_d  = cfg.rate_code;
		baud_div_d   = cfg.baud_div;
		addr_nv_d    = cfg.addr_nv;
		rate_nv_d    = cfg.rate_nv;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_q         <= 8'h00;
			sel_q        <= 1'b1;
			rs485_mode_q <= 1'b0;
			node_addr_q  <= NV_ADDR_RST;
			rate_code_q  <= RATE_9K6;
			baud_div_q   <= DIV_9K6;
			addr_nv_q    <= 1'b1;
			rate_nv_q    <= 1'b1;
		end else begin
			sw_q         <= sw_d;
			sel_q        <= sel_d;
			rs485_mode_q <= rs485_mode_d;
			node_addr_q  <= node_addr_d;
			rate_code_q  <= rate_code_d;
			baud_div_q   <= baud_div_d;
			addr_nv_q    <= addr_nv_d;
			rate_nv_q    <= rate_nv_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign rs485_mode   = rs485_mode_q;
	assign node_addr    = node_addr_q;
	assign rate_code    = rate_code_q;
	assign baud_div     = baud_div_q;
	assign addr_from_nv = addr_nv_q;
	assign rate_from_nv = rate_nv_q;
	assign rs232_cfg    = rs232_cfg_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	addr_switch_a: assert property ( // R1
		sw_q[ADDR_LSB +: ADDR_W] != ADDR_USE_NV
		|=> node_addr_q == $past(sw_q[ADDR_LSB +: ADDR_W]) && !addr_nv_q)
		else $error("node address does not follow switches");

	rate_switch_a: assert property ( // R2
		sw_q[RATE_LSB +: RATE_W] != RATE_USE_NV
		|=> rate_code_q == $past(sw_q[RATE_LSB +: RATE_W]) && !rate_nv_q)
		else $error("rate code does not follow switches");

	rs232_untouched_a: assert property ( // R3
		!(wr_en && paddr == OFS_RS232) |=> $stable(rs232_cfg_q))
		else $error("RS-232 settings changed without a write");

	addr_stored_a: assert property ( // R4
		sw_closed[ADDR_LSB +: ADDR_W] == ADDR_USE_NV ##1 !wr_en
		|=> addr_nv_q && node_addr_q == $past(nv_addr_q))
		else $error("zero address switches did not use stored address");

	rate_stored_a: assert property ( // R5
		sw_q[RATE_LSB +: RATE_W] == RATE_USE_NV && nv_rate_q != RATE_USE_NV
		|=> rate_nv_q && rate_code_q == $past(nv_rate_q))
		else $error("zero rate switches did not use stored rate");

	rate_divider_a: assert property ( // R6
		(rate_code_q == RATE_9K6   && baud_div_q == DIV_9K6)  ||
		(rate_code_q == RATE_38K4  && baud_div_q == DIV_38K4) ||
		(rate_code_q == RATE_115K2 && baud_div_q == DIV_115K2))
		else $error("bit rate divider does not match rate code");

	mode_rs485_a: assert property ( // R7
		!select_pin |=> ##1 rs485_mode_q)
		else $error("grounded select did not give RS-485");

	mode_rs232_a: assert property ( // R7
		$rose(select_pin) |=> ##1 $fell(rs485_mode_q))
		else $error("released select did not give RS-232");

	apb_ready_a: assert property (
		setup |=> pready_q ##1 !pready_q || (psel && !penable))
		else $error("APB answer not one cycle after setup");

	addr_latency_a: assert property ( // R1
		sw_closed[ADDR_LSB +: ADDR_W] != ADDR_USE_NV
		|=> ##1 node_addr_q == $past(sw_closed[ADDR_LSB +: ADDR_W], 2))
		else $error("node address lags switches by more than two edges");

	rate_latency_a: assert property ( // R2
		sw_closed[RATE_LSB +: RATE_W] != RATE_USE_NV
		|=> ##1 rate_code_q == $past(sw_closed[RATE_LSB +: RATE_W], 2))
		else $error("rate code lags switches by more than two edges");

	rate_default_a: assert property ( // R5
		sw_q[RATE_LSB +: RATE_W] == RATE_USE_NV &&
		nv_rate_q == RATE_USE_NV
		|=> rate_nv_q && rate_code_q == RATE_9K6)
		else $error("empty stored rate did not give the slowest rate");

	nv_write_a: assert property ( // R4 R5
		wr_en && paddr == OFS_NV_CFG
		|=> nv_addr_q == $past(pwdata[NV_ADDR_LSB +: ADDR_W]) &&
		nv_rate_q == $past(pwdata[NV_RATE_LSB +: RATE_W]))
		else $error("stored address or rate not written");

	rs232_write_a: assert property ( // R3
		wr_en && paddr == OFS_RS232
		|=> rs232_cfg_q == $past(pwdata[RS232_W-1:0]))
		else $error("RS-232 settings not written");

	status_read_a: assert property ( // R7
		setup && !pwrite && paddr == OFS_STATUS
		|=> prdata_q[ST_RS485] == $past(rs485_mode_q) &&
		prdata_q[ST_ADDR_LSB +: ADDR_W] == $past(node_addr_q))
		else $error("status read does not show decoded values");

	// ************************************************************
	// APB answer checks and cover points
	// ************************************************************

	apb_error_a: assert property (
		setup && !mapped
		|=> pready_q && pslverr_q && prdata_q == 32'h0000_0000)
		else $error("unmapped access not refused");

	apb_mapped_a: assert property (
		setup && mapped |=> pready_q && !pslverr_q)
		else $error("mapped access answered with an error");

	ready_pulse_a: assert property (
		pready_q |=> !pready_q)
		else $error("ready held for more than one cycle");

	idle_quiet_a: assert property (
		!psel |=> !pready_q && !pslverr_q)
		else $error("answer without a request");

	cov_addr_nv: cover property (addr_nv_q && rs485_mode_q);
	cov_fast_rate: cover property (rate_code_q == RATE_115K2 && !rate_nv_q);
	cov_rate_nv: cover property (rate_nv_q && rate_code_q == RATE_38K4);
	cov_apb_err: cover property (pready_q && pslverr_q);
	cov_rs232_mode: cover property (!rs485_mode_q && !addr_nv_q);

endmodule // serial_node_switch_config

// ### sw_bank_model.sv
// Purpose: Switch bank and select pin as the outside party sets them
// Assumes: New settings land on a rising pclk edge
// Notes:   Select pin is pulled up (RS-232) while in reset
`timescale 1ns/1ps
module sw_bank_model
	import serial_cfg_pkg::*;
(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic [SW_W-1:0] want_sw,
	input  wire logic            want_gnd,
	output logic      [SW_W-1:0] sw_closed,
	output logic                 select_pin
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_closed  <= 8'h00;
			select_pin <= 1'b1;
		end else begin
			sw_closed  <= want_sw;
			select_pin <= !want_gnd;
		end
	end
endmodule // sw_bank_model

// ### serial_node_switch_config_test.sv
// Purpose: Self-checking bench for the switch configuration block
// Assumes: Master waits on pready; no fixed answer time
// Notes:   Results are read back through STATUS and BAUDDIV
`timescale 1ns/1ps
module serial_node_switch_config_test;
	import serial_cfg_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, sel_pin, rs485_mode;
	logic [PADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, e_w, ex;
	logic [SW_W-1:0] sw_c, want_sw = 8'h00, s;
	logic want_gnd = 1'b0, addr_from_nv, rate_from_nv, g;
	logic [ADDR_W-1:0] node_addr;
	logic [RATE_W-1:0] rate_code, nr;
	logic [DIV_W-1:0] baud_div;
	logic [RS232_W-1:0] rs232_cfg;
	logic [15:0] v;
	logic [31:0] q[$];
	int err_count = 0;
	int compares = 0;

	always #10 pclk = ~pclk;

	sw_bank_model sw_bank_model_i (.pclk(pclk), .presetn(presetn),
		.want_sw(want_sw), .want_gnd(want_gnd), .sw_closed(sw_c),
		.select_pin(sel_pin));
	serial_node_switch_config serial_node_switch_config_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sw_closed(sw_c),
		.select_pin(sel_pin), .rs485_mode(rs485_mode),
		.node_addr(node_addr), .rate_code(rate_code), .baud_div(baud_div),
		.addr_from_nv(addr_from_nv), .rate_from_nv(rate_from_nv),
		.rs232_cfg(rs232_cfg));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [31:0] st_exp(input logic [7:0] sw,
		input logic [5:0] na, input logic [1:0] r, input logic gnd);
		logic an;
		logic rn;
		an = (sw[5:0] == 6'h00);
		rn = (sw[7:6] == 2'h0);
		if (!rn)
			r = sw[7:6];
		else if (r == 2'h0)
			r = 2'h1;
		st_exp = {11'h0, gnd, rn, an, r, 2'h0, an ? na : sw[5:0], sw};
	endfunction

	function automatic logic [12:0] div_of(input logic [1:0] r);
		div_of = (r == 2'h3) ? DIV_115K2 : (r == 2'h2) ? DIV_38K4 : DIV_9K6;
	endfunction

	task automatic miss(input logic [31:0] e, input logic [31:0] g);
		err_count++;
		$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
	endtask

	task automatic final_report();
		$display("errors=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask

	// ************************************************************
	// Result watcher
	// ************************************************************
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			compares++;
			e_w = (q.size() > 0) ? q.pop_front() : 32'hffffffff;
			if (prdata !== e_w)
				miss(e_w, prdata);
			if (pslverr !== (paddr > OFS_BAUDDIV))
				miss({31'h0, paddr > OFS_BAUDDIV}, {31'h0, pslverr});
			if (paddr == OFS_STATUS && {rs485_mode, rate_from_nv,
				addr_from_nv, rate_code, 2'h0, node_addr} !== e_w[20:8])
				miss(e_w, {11'h0, rs485_mode, rate_from_nv, addr_from_nv,
					rate_code, 2'h0, node_addr, 8'h00});
			if (paddr == OFS_BAUDDIV && baud_div !== e_w[12:0])
				miss(e_w, {19'h0, baud_div});
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		v = 16'h0063;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b1, OFS_RS232, {16'h0, v});
		for (int i = 0; i < 12; i++) begin
			v = lfsr(v);
			s = v[7:0];
			if (i < 4)
				s = {i[1:0], 6'h00};
			if (i == 4)
				s = {2'h0, v[5:0] | 6'h01};
			nr = (i == 0) ? 2'h0 : v[15:14];
			g = (i < 2) ? i[0] : v[11];
			xfer(1'b1, OFS_NV_CFG, {22'h0, nr, 2'h0, v[13:8]});
			want_sw <= s;
			want_gnd <= g;
			repeat (4) @(posedge pclk);
			ex = st_exp(s, v[13:8], nr, g);
			rd(OFS_STATUS, ex);
			rd(OFS_BAUDDIV, {19'h0, div_of(ex[17:16])});
		end
		rd(OFS_RS232, {16'h0, 16'h0063});
		rd(12'h010, 32'h0);
		compares++;
		if (rs232_cfg !== 16'h0063)
			miss(32'h63, {16'h0, rs232_cfg});
		repeat (2) @(posedge pclk);
		final_report();
	end
endmodule // serial_node_switch_config_test
